/* File: shared/sampler_pkg.sv */
// constants shared by the sampler state decoder and its requesting core
`default_nettype none
package sampler_pkg;
  localparam int LOD_W = 10;
  localparam int SLOD_W = 11;
  localparam int FRAC_W = 6;
  localparam int LVL_W = 4;
  // descriptor second word fields
  localparam int UPPER_LSB = 12;
  localparam int CUBE_CTRL_BIT = 9;
  localparam int FIRST_AXIS_LSB = 6;
  localparam int SECOND_AXIS_LSB = 3;
  localparam int THIRD_AXIS_LSB = 0;
  localparam logic [31:0] WORD1_ZERO_MASK = 32'h0000_0C00;
  // descriptor fourth word fields
  localparam int KEY_EN_BIT = 25;
  localparam int KEY_IDX_LSB = 23;
  localparam int KEY_MODE_BIT = 22;
  localparam int ANISO_LSB = 19;
  localparam logic [31:0] WORD3_ZERO_MASK = 32'hFC00_0000;
  localparam logic [9:0] UPPER_CEIL = 10'h340;
  localparam logic cube_use_programmed = 1'b0;
  localparam logic cube_force_face_mode = 1'b1;
  localparam logic [2:0] addr_repeat = 3'h0;
  localparam logic [2:0] addr_reflect = 3'h1;
  localparam logic [2:0] addr_edge_clamp = 3'h2;
  localparam logic [2:0] addr_cube_face = 3'h3;
  localparam logic [2:0] addr_border_clamp = 3'h4;
  localparam logic [2:0] addr_reflect_once = 3'h5;
  localparam logic [2:0] aniso_filter_mode = 3'h2;
  localparam logic [2:0] monochrome_conv_filter = 3'h6;
  localparam logic key_drop_pixel = 1'b0;
  localparam logic key_zero_texel = 1'b1;
  localparam logic [2:0] ratio_cap_two = 3'h0;
  localparam logic [2:0] ratio_cap_sixteen = 3'h7;
  localparam logic [31:0] LUMA_CHROMA_FILL = 32'h0080_1080;
  // controller register offsets
  localparam logic [4:0] DESC1_OFS = 5'h00;
  localparam logic [4:0] DESC3_OFS = 5'h04;
  localparam logic [4:0] REQ_LOD_OFS = 5'h08;
  localparam logic [4:0] REQ_CTRL_OFS = 5'h0C;
  localparam logic [4:0] GO_STATUS_OFS = 5'h10;
  localparam logic [4:0] RESULT0_OFS = 5'h14;
  localparam logic [4:0] RESULT1_OFS = 5'h18;
  localparam logic [4:0] RESULT2_OFS = 5'h1C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: shared/sampler_link_if.sv */
// link between a requesting core and the sampler state decoder
`timescale 1ns/100ps
`default_nettype none
interface sampler_link_if;
  logic req_valid;
  logic req_ready;
  logic [31:0] word1;
  logic [31:0] word3;
  logic signed [10:0] biased_lod;
  logic [9:0] lower_detail_limit;
  logic cube_surface;
  logic volume_surface;
  logic [2:0] min_filter;
  logic [2:0] mag_filter;
  logic mip_linear;
  logic [3:0] texel_match;
  logic pixel_mask;
  logic kill_mask_req;
  logic luma_chroma;
  logic rsp_valid;
  logic rsp_ready;
  logic [9:0] lod_out;
  logic [3:0] fine_level;
  logic [3:0] coarse_level;
  logic [5:0] blend;
  logic magnify;
  logic [8:0] addr_modes;
  logic border_zero;
  logic mono_active;
  logic key_enable;
  logic [1:0] key_index;
  logic pixel_mask_out;
  logic [3:0] zero_texel;
  logic [31:0] fill_value;
  logic [4:0] aniso_ratio;
  modport device_end (
    input req_valid, word1, word3, biased_lod, lower_detail_limit, cube_surface,
    volume_surface, min_filter, mag_filter, mip_linear, texel_match, pixel_mask,
    kill_mask_req, luma_chroma, rsp_ready,
    output req_ready, rsp_valid, lod_out, fine_level, coarse_level, blend, magnify,
    addr_modes, border_zero, mono_active, key_enable, key_index, pixel_mask_out,
    zero_texel, fill_value, aniso_ratio
  );
  modport core_end (
    output req_valid, word1, word3, biased_lod, lower_detail_limit, cube_surface,
    volume_surface, min_filter, mag_filter, mip_linear, texel_match, pixel_mask,
    kill_mask_req, luma_chroma, rsp_ready,
    input req_ready, rsp_valid, lod_out, fine_level, coarse_level, blend, magnify,
    addr_modes, border_zero, mono_active, key_enable, key_index, pixel_mask_out,
    zero_texel, fill_value, aniso_ratio
  );
endinterface
`default_nettype wire

/* File: hw/addr_mode_resolve.sv */
// resolves one axis addressing mode against cube override and reserved codes
`timescale 1ns/100ps
`default_nettype none
module addr_mode_resolve (
  input wire logic [2:0] programmed,
  input wire logic cube_surface,
  input wire logic cube_ctrl,
  output logic [2:0] resolved
);
  always_comb begin
    if (cube_surface && cube_ctrl == sampler_pkg::cube_force_face_mode) begin
      resolved = sampler_pkg::addr_cube_face;
    end else begin
      unique case (programmed)
        sampler_pkg::addr_repeat, sampler_pkg::addr_reflect, sampler_pkg::addr_edge_clamp,
        sampler_pkg::addr_cube_face, sampler_pkg::addr_border_clamp,
        sampler_pkg::addr_reflect_once: resolved = programmed;
        default: resolved = sampler_pkg::addr_edge_clamp;
      endcase
    end
  end
endmodule // addr_mode_resolve
`default_nettype wire

/* File: hw/sampler_state_decode.sv */
// device end: decodes sampler descriptor fields for one sampling request
`timescale 1ns/100ps
`default_nettype none
// What this block and the core end do
// - clamp biased detail level to upper limit
// - magnify decision uses level before clamp
// - upper limit bounds level and blend
// - levels between lower int and upper ceiling
// - lower limit wins when above upper
// - cube control forces cube addressing mode
// - first axis mode three-bit code decode
// - second, third axis use same decode
// - cube coordinates use same clamp or cube
// - convolution filter sets border clamp everywhere unless cube control forces cube
// - no reflect modes with unorm messages
// - third axis border clamp returns zero
// - enable bit turns key comparison on
// - no keying with mono, aniso, volume
// - key index selects entry, ignored disabled
// - drop mode clears matching pixel mask
// - zero mode replaces matching texels
// - anisotropy ratio capped at 2(n+1)
// - reserved descriptor bits written as zero
// - code 6h is monochrome convolution filter
// - code 2h is anisotropic filter
module sampler_state_decode (
  input wire logic aclk,
  input wire logic aresetn,
  sampler_link_if.device_end link
);
  typedef enum logic [1:0] {IDLE, EVAL, RESP} phase_e;
  phase_e phase_reg;
  logic [31:0] word1_reg;
  logic [31:0] word3_reg;
  logic signed [10:0] lod_reg;
  logic [9:0] lower_reg;
  logic cube_reg;
  logic volume_reg;
  logic [2:0] min_filter_reg;
  logic [2:0] mag_filter_reg;
  logic mip_linear_reg;
  logic [3:0] match_reg;
  logic pixel_mask_reg;
  logic kill_req_reg;
  logic luma_reg;
  logic [8:0] modes;
  logic [9:0] upper;
  logic [9:0] lod_pos;
  logic [9:0] final_lod;
  logic [3:0] level_hi;
  logic [3:0] level_lo;
  logic [3:0] bound_hi;
  logic [3:0] coarse;
  logic key_on;
  logic aniso_on;
  logic [9:0] lod_out_reg;
  logic [3:0] fine_reg;
  logic [3:0] coarse_reg;
  logic [5:0] blend_reg;
  logic magnify_reg;
  logic [8:0] modes_reg;
  logic border_zero_reg;
  logic mono_reg;
  logic key_en_reg;
  logic [1:0] key_idx_reg;
  logic mask_out_reg;
  logic [3:0] zero_texel_reg;
  logic [31:0] fill_reg;
  logic [4:0] ratio_reg;

  function automatic logic [9:0] min10(input logic [9:0] a, input logic [9:0] b);
    min10 = (a < b) ? a : b;
  endfunction

  function automatic logic [3:0] ceil_level(input logic [9:0] v);
    ceil_level = v[9:6] + {3'h0, |v[5:0]};
  endfunction

  assign link.req_ready = (phase_reg == IDLE);
  assign link.rsp_valid = (phase_reg == RESP);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg <= IDLE;
    end else begin
      unique case (phase_reg)
        IDLE: if (link.req_valid) phase_reg <= EVAL;
        EVAL: phase_reg <= RESP;
        RESP: if (link.rsp_ready) phase_reg <= IDLE;
      endcase
    end
  end

  // request fields are captured once and held until the answer is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word1_reg <= 32'h0;
      word3_reg <= 32'h0;
      lod_reg <= 11'sh0;
      lower_reg <= 10'h0;
      cube_reg <= 1'b0;
      volume_reg <= 1'b0;
      min_filter_reg <= 3'h0;
      mag_filter_reg <= 3'h0;
      mip_linear_reg <= 1'b0;
      match_reg <= 4'h0;
      pixel_mask_reg <= 1'b0;
      kill_req_reg <= 1'b0;
      luma_reg <= 1'b0;
    end else if (phase_reg == IDLE && link.req_valid) begin
      word1_reg <= link.word1;
      word3_reg <= link.word3;
      lod_reg <= link.biased_lod;
      lower_reg <= link.lower_detail_limit;
      cube_reg <= link.cube_surface;
      volume_reg <= link.volume_surface;
      min_filter_reg <= link.min_filter;
      mag_filter_reg <= link.mag_filter;
      mip_linear_reg <= link.mip_linear;
      match_reg <= link.texel_match;
      pixel_mask_reg <= link.pixel_mask;
      kill_req_reg <= link.kill_mask_req;
      luma_reg <= link.luma_chroma;
    end
  end

  for (genvar a = 0; a < 3; a++) begin : g_axis
    addr_mode_resolve u_resolve (
      .programmed(word1_reg[3*a +: 3]),
      .cube_surface(cube_reg),
      .cube_ctrl(word1_reg[sampler_pkg::CUBE_CTRL_BIT]),
      .resolved(modes[3*a +: 3])
    );
  end

  // detail level arithmetic
  always_comb begin
    upper = min10(word1_reg[sampler_pkg::UPPER_LSB +: 10], sampler_pkg::UPPER_CEIL);
    lod_pos = lod_reg[10] ? 10'h0 : lod_reg[9:0];
    if (lower_reg > upper) begin
      final_lod = lower_reg;
    end else if (lod_pos < lower_reg) begin
      final_lod = lower_reg;
    end else begin
      final_lod = min10(lod_pos, upper);
    end
    level_lo = lower_reg[9:6];
    level_hi = ceil_level(upper);
    bound_hi = (level_hi < level_lo) ? level_lo : level_hi;
    coarse = (mip_linear_reg && |final_lod[5:0]) ? final_lod[9:6] + 4'h1 : final_lod[9:6];
    if (coarse > bound_hi || coarse < final_lod[9:6]) begin
      coarse = bound_hi;
    end
    key_on = word3_reg[sampler_pkg::KEY_EN_BIT];
    aniso_on = (min_filter_reg == sampler_pkg::aniso_filter_mode) ||
               (mag_filter_reg == sampler_pkg::aniso_filter_mode);
  end

  // answer registers are loaded in the evaluation cycle only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lod_out_reg <= 10'h0;
      fine_reg <= 4'h0;
      coarse_reg <= 4'h0;
      blend_reg <= 6'h0;
      magnify_reg <= 1'b0;
      modes_reg <= 9'h0;
      border_zero_reg <= 1'b0;
      mono_reg <= 1'b0;
    end else if (phase_reg == EVAL) begin
      lod_out_reg <= final_lod;
      fine_reg <= final_lod[9:6];
      coarse_reg <= coarse;
      blend_reg <= mip_linear_reg ? final_lod[5:0] : 6'h0;
      magnify_reg <= (lod_reg <= 11'sh0);
      modes_reg <= modes;
      border_zero_reg <= (modes[2:0] == sampler_pkg::addr_border_clamp);
      mono_reg <= (min_filter_reg == sampler_pkg::monochrome_conv_filter) ||
                  (mag_filter_reg == sampler_pkg::monochrome_conv_filter);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_en_reg <= 1'b0;
      key_idx_reg <= 2'h0;
      mask_out_reg <= 1'b1;
      zero_texel_reg <= 4'h0;
      fill_reg <= 32'h0;
      ratio_reg <= 5'h0;
    end else if (phase_reg == EVAL) begin
      key_en_reg <= key_on;
      key_idx_reg <= key_on ? word3_reg[sampler_pkg::KEY_IDX_LSB +: 2] : 2'h0;
      if (key_on && word3_reg[sampler_pkg::KEY_MODE_BIT] == sampler_pkg::key_drop_pixel &&
          |match_reg && kill_req_reg) begin
        mask_out_reg <= 1'b0;
      end else begin
        mask_out_reg <= pixel_mask_reg | ~kill_req_reg;
      end
      if (key_on && word3_reg[sampler_pkg::KEY_MODE_BIT] == sampler_pkg::key_zero_texel) begin
        zero_texel_reg <= match_reg;
      end else begin
        zero_texel_reg <= 4'h0;
      end
      fill_reg <= luma_reg ? sampler_pkg::LUMA_CHROMA_FILL : 32'h0;
      ratio_reg <= aniso_on ? {1'b0, word3_reg[sampler_pkg::ANISO_LSB +: 3], 1'b0} + 5'h2
                            : 5'h0;
    end
  end

  assign link.lod_out = lod_out_reg;
  assign link.fine_level = fine_reg;
  assign link.coarse_level = coarse_reg;
  assign link.blend = blend_reg;
  assign link.magnify = magnify_reg;
  assign link.addr_modes = modes_reg;
  assign link.border_zero = border_zero_reg;
  assign link.mono_active = mono_reg;
  assign link.key_enable = key_en_reg;
  assign link.key_index = key_idx_reg;
  assign link.pixel_mask_out = mask_out_reg;
  assign link.zero_texel = zero_texel_reg;
  assign link.fill_value = fill_reg;
  assign link.aniso_ratio = ratio_reg;
endmodule // sampler_state_decode
`default_nettype wire

/* File: hw/sampler_core_ctrl.sv */
// core end: AXI4-Lite controlled issuer of sampling requests
`timescale 1ns/100ps
`default_nettype none
module sampler_core_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  sampler_link_if.core_end link
);
  logic [31:0] desc1_reg, desc3_reg, lod_reg, ctrl_reg;
  logic [31:0] res0_reg, res1_reg, res2_reg;
  logic busy_reg, done_reg, adjusted_reg;
  logic [31:0] w1_next, w3_next;
  logic [1:0] bresp_reg, rresp_reg;
  logic bvalid_reg, rvalid_reg;
  logic [31:0] rdata_reg;
  logic wr_go, mono, cube, unorm, bad_cube;
  logic [2:0] m;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = s[i] ? d[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  function automatic logic mapped(input logic [4:0] a);
    mapped = (a[1:0] == 2'h0);
  endfunction

  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !rvalid_reg;

  // descriptor words are made legal before they reach the decoder
  always_comb begin
    w1_next = desc1_reg & ~sampler_pkg::WORD1_ZERO_MASK;
    w3_next = desc3_reg & ~sampler_pkg::WORD3_ZERO_MASK;
    mono = ctrl_reg[4:2] == sampler_pkg::monochrome_conv_filter ||
           ctrl_reg[7:5] == sampler_pkg::monochrome_conv_filter;
    cube = ctrl_reg[0];
    unorm = ctrl_reg[16];
    m = desc1_reg[8:6];
    bad_cube = cube && ((m != sampler_pkg::addr_edge_clamp && m != sampler_pkg::addr_cube_face)
               || desc1_reg[5:3] != m || desc1_reg[2:0] != m);
    if (mono) begin
      w1_next[8:0] = {3{sampler_pkg::addr_border_clamp}};
    end else if (bad_cube) begin
      w1_next[8:0] = {3{sampler_pkg::addr_edge_clamp}};
    end else if (unorm) begin
      for (int a = 0; a < 3; a++) begin
        if (desc1_reg[3*a +: 3] == sampler_pkg::addr_reflect ||
            desc1_reg[3*a +: 3] == sampler_pkg::addr_reflect_once) begin
          w1_next[3*a +: 3] = sampler_pkg::addr_edge_clamp;
        end
      end
    end
    if (mono || ctrl_reg[1] || ctrl_reg[4:2] == sampler_pkg::aniso_filter_mode ||
        ctrl_reg[7:5] == sampler_pkg::aniso_filter_mode) begin
      w3_next[sampler_pkg::KEY_EN_BIT] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      desc1_reg <= 32'h0;
      desc3_reg <= 32'h0;
      lod_reg <= 32'h0;
      ctrl_reg <= 32'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= sampler_pkg::RESP_OKAY;
    end else begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(s_axi_awaddr) ? sampler_pkg::RESP_OKAY : sampler_pkg::RESP_SLVERR;
        unique case (s_axi_awaddr)
          sampler_pkg::DESC1_OFS: desc1_reg <= merge(desc1_reg, s_axi_wdata, s_axi_wstrb);
          sampler_pkg::DESC3_OFS: desc3_reg <= merge(desc3_reg, s_axi_wdata, s_axi_wstrb);
          sampler_pkg::REQ_LOD_OFS: lod_reg <= merge(lod_reg, s_axi_wdata, s_axi_wstrb);
          sampler_pkg::REQ_CTRL_OFS: ctrl_reg <= merge(ctrl_reg, s_axi_wdata, s_axi_wstrb);
          default: ;
        endcase
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // a go write launches one request; done stays set until the next launch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      adjusted_reg <= 1'b0;
      res0_reg <= 32'h0;
      res1_reg <= 32'h0;
      res2_reg <= 32'h0;
    end else if (busy_reg) begin
      if (link.rsp_valid) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
        res0_reg <= {link.zero_texel, link.mono_active, link.border_zero, link.pixel_mask_out,
                     link.magnify, link.blend, link.coarse_level, link.fine_level, link.lod_out};
        res1_reg <= {15'h0, link.aniso_ratio, link.key_index, link.key_enable, link.addr_modes};
        res2_reg <= link.fill_value;
      end
    end else if (wr_go && s_axi_awaddr == sampler_pkg::GO_STATUS_OFS && s_axi_wstrb[0] &&
                 s_axi_wdata[0]) begin
      busy_reg <= 1'b1;
      done_reg <= 1'b0;
      adjusted_reg <= (w1_next != desc1_reg) || (w3_next != desc3_reg);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= sampler_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= mapped(s_axi_araddr) ? sampler_pkg::RESP_OKAY : sampler_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        sampler_pkg::DESC1_OFS: rdata_reg <= desc1_reg;
        sampler_pkg::DESC3_OFS: rdata_reg <= desc3_reg;
        sampler_pkg::REQ_LOD_OFS: rdata_reg <= lod_reg;
        sampler_pkg::REQ_CTRL_OFS: rdata_reg <= ctrl_reg;
        sampler_pkg::GO_STATUS_OFS: rdata_reg <= {29'h0, adjusted_reg, done_reg, busy_reg};
        sampler_pkg::RESULT0_OFS: rdata_reg <= res0_reg;
        sampler_pkg::RESULT1_OFS: rdata_reg <= res1_reg;
        sampler_pkg::RESULT2_OFS: rdata_reg <= res2_reg;
        default: rdata_reg <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign link.req_valid = busy_reg && !link.rsp_valid;
  assign link.rsp_ready = 1'b1;
  assign link.word1 = w1_next;
  assign link.word3 = w3_next;
  assign link.biased_lod = lod_reg[10:0];
  assign link.lower_detail_limit = lod_reg[25:16];
  assign link.cube_surface = ctrl_reg[0];
  assign link.volume_surface = ctrl_reg[1];
  assign link.min_filter = ctrl_reg[4:2];
  assign link.mag_filter = ctrl_reg[7:5];
  assign link.mip_linear = ctrl_reg[8];
  assign link.texel_match = ctrl_reg[12:9];
  assign link.pixel_mask = ctrl_reg[13];
  assign link.kill_mask_req = ctrl_reg[14];
  assign link.luma_chroma = ctrl_reg[15];
endmodule // sampler_core_ctrl
`default_nettype wire

/* File: testbench/sampler_link_monitor.sv */
// concurrent checks on the link between the requesting core and the state decoder
`timescale 1ns/100ps
`default_nettype none
module sampler_link_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [31:0] word1,
  input wire logic [31:0] word3,
  input wire logic signed [10:0] biased_lod,
  input wire logic [9:0] lower_detail_limit,
  input wire logic cube_surface,
  input wire logic [2:0] min_filter,
  input wire logic [2:0] mag_filter,
  input wire logic [3:0] texel_match,
  input wire logic kill_mask_req,
  input wire logic [9:0] lod_out,
  input wire logic [3:0] fine_level,
  input wire logic [3:0] coarse_level,
  input wire logic magnify,
  input wire logic [8:0] addr_modes,
  input wire logic key_enable,
  input wire logic [1:0] key_index,
  input wire logic pixel_mask_out,
  input wire logic [4:0] aniso_ratio
);
  default clocking mon_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [9:0] upper;
  assign upper = word1[21:12];
  a_answer_two_edges: assert property (
    req_valid && req_ready |=> !req_ready && !rsp_valid ##1 rsp_valid)
    else $error("response not two edges after request");
  a_upper_clamp: assert property (
    rsp_valid && lower_detail_limit <= upper |-> lod_out <= upper && lod_out >= lower_detail_limit)
    else $error("detail level outside limits");
  a_lower_wins: assert property (
    rsp_valid && lower_detail_limit > upper |-> lod_out == lower_detail_limit)
    else $error("lower limit did not win");
  a_magnify_preclamp: assert property (
    rsp_valid |-> magnify == (biased_lod <= 11'sd0))
    else $error("magnify not from biased level");
  a_level_range: assert property (
    rsp_valid |-> fine_level == lod_out[9:6] && coarse_level >= fine_level
      && {1'b0, coarse_level} <= {1'b0, fine_level} + 5'h01)
    else $error("mip levels out of range");
  a_cube_override: assert property (
    rsp_valid && cube_surface && word1[9] |-> addr_modes == {3{sampler_pkg::addr_cube_face}})
    else $error("cube override not applied");
  a_reserved_clamp: assert property (
    rsp_valid && !cube_surface && word1[8:7] == 2'h3 |-> addr_modes[8:6] == 3'h2)
    else $error("reserved mode not edge clamp");
  a_key_index_off: assert property (
    rsp_valid && !key_enable |-> key_index == 2'h0)
    else $error("key index shown while keying off");
  a_drop_clears: assert property (
    rsp_valid && key_enable && !word3[22] && |texel_match && kill_mask_req |-> !pixel_mask_out)
    else $error("matching pixel not dropped");
  a_aniso_cap: assert property (
    rsp_valid && (min_filter == 3'h2 || mag_filter == 3'h2)
      |-> aniso_ratio == {word3[21:19], 1'b0} + 5'h02)
    else $error("anisotropy cap wrong");
  c_key_on: cover property (rsp_valid && key_enable);
  c_ratio_max: cover property (rsp_valid && aniso_ratio == 5'h10);
  c_lower_above: cover property (rsp_valid && lower_detail_limit > upper);
endmodule // sampler_link_monitor
`default_nettype wire

/* File: testbench/test_texture_sampler_state_decode.sv */
// self-checking bench: core and state decoder joined by their link
`timescale 1ns/100ps
`default_nettype none
module test_texture_sampler_state_decode;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h00000000, rdata, lf = 32'h0000EB54;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int error_cnt = 0, comparisons = 0;
  logic [31:0] cor [10][4] = '{'{32'h200, 0, 32'h40, 1}, '{32'hDB, 0, 0, 1},
    '{32'hDBC, 32'h1C000000, 0, 0}, '{0, 32'h2000000, 0, 32'hC0},
    '{0, 32'h3800000, 0, 32'h7E00}, '{0, 32'h2400000, 0, 32'h1A00},
    '{32'h100000, 0, 32'h2000050, 0}, '{32'h3FF000, 0, 32'h3FF, 32'h100},
    '{32'h68, 0, 32'h7C0, 32'h10000}, '{0, 32'h2000000, 0, 2}};
  sampler_link_if link();
  always #20 aclk = ~aclk;
  sampler_state_decode u_sampler_state_decode (.aclk(aclk), .aresetn(aresetn), .link(link));
  sampler_core_ctrl u_sampler_core_ctrl (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link(link));
  sampler_link_monitor u_sampler_link_monitor (.aclk(aclk), .aresetn(aresetn),
    .req_valid(link.req_valid), .req_ready(link.req_ready), .rsp_valid(link.rsp_valid),
    .word1(link.word1), .word3(link.word3), .biased_lod(link.biased_lod),
    .lower_detail_limit(link.lower_detail_limit), .cube_surface(link.cube_surface),
    .min_filter(link.min_filter), .mag_filter(link.mag_filter),
    .texel_match(link.texel_match), .kill_mask_req(link.kill_mask_req),
    .lod_out(link.lod_out), .fine_level(link.fine_level), .coarse_level(link.coarse_level),
    .magnify(link.magnify), .addr_modes(link.addr_modes), .key_enable(link.key_enable),
    .key_index(link.key_index), .pixel_mask_out(link.pixel_mask_out),
    .aniso_ratio(link.aniso_ratio));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic stop_test();
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
  endtask
  task automatic run_req(input logic [31:0] d1, d3, lr, c);
    logic [1:0] r;
    logic [31:0] st, r0, r1, r2;
    logic [2:0] m;
    logic [8:0] em;
    logic an, mo, ke;
    int up, lo, b, lod;
    an = c[4:2] == 3'h2 || c[7:5] == 3'h2;
    mo = c[4:2] == 3'h6 || c[7:5] == 3'h6;
    ke = d3[25] && !an && !mo && !c[1];
    for (int i = 0; i < 3; i++) begin
      m = d1[i*3+:3];
      if (mo) m = sampler_pkg::addr_border_clamp;
      if (c[16] && (m == 3'h1 || m == 3'h5)) m = 3'h2;
      if (m > 3'h5) m = 3'h2;
      em[i*3+:3] = m;
    end
    if (c[0] && d1[9]) em = 9'o333;
    else if (c[0] && !mo &&
             !(em[8:6] == em[5:3] && em[5:3] == em[2:0] && em[2:1] == 2'h1)) em = 9'o222;
    up = d1[21:12] > 10'h340 ? 'h340 : d1[21:12];
    lo = lr[25:16];
    b = $signed(lr[10:0]);
    lod = lo > up ? lo : (b < lo ? lo : (b > up ? up : b));
    axi_wr(sampler_pkg::DESC1_OFS, d1, r);
    axi_wr(sampler_pkg::DESC3_OFS, d3, r);
    axi_wr(sampler_pkg::REQ_LOD_OFS, lr, r);
    axi_wr(sampler_pkg::REQ_CTRL_OFS, c, r);
    axi_wr(sampler_pkg::GO_STATUS_OFS, 32'h00000001, r);
    st = 32'h0;
    repeat (20) if (st[1:0] !== 2'h2) axi_rd(sampler_pkg::GO_STATUS_OFS, st);
    check("status", 2, st & 32'h3);
    axi_rd(sampler_pkg::RESULT0_OFS, r0);
    axi_rd(sampler_pkg::RESULT1_OFS, r1);
    axi_rd(sampler_pkg::RESULT2_OFS, r2);
    check("lod", lod, r0[9:0]);
    check("blend", c[8] ? lod[5:0] : 0, r0[23:18]);
    check("mono", mo, r0[27]);
    check("fill", c[15] ? 32'h00801080 : 0, r2);
    check("magnify", b <= 0, r0[24]);
    check("modes", em, r1[8:0]);
    check("border_zero", em[2:0] == 3'h4, r0[26]);
    check("key_en", ke, r1[9]);
    check("key_idx", ke ? d3[24:23] : 0, r1[11:10]);
    check("mask", ke && !d3[22] && |c[12:9] && c[14] ? 0 : (c[14] ? c[13] : 1), r0[25]);
    check("zero_texel", ke && d3[22] ? c[12:9] : 0, r0[31:28]);
    check("aniso", an ? 2 * (d3[21:19] + 1) : 0, r1[16:12]);
    check("zero_bits", 0, link.word1 & 32'h00000C00 | link.word3 & 32'hFC000000);
  endtask
  initial begin
    logic [1:0] r;
    logic [31:0] d, d1, d3, lr, c;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_wr(5'h02, 32'hFFFFFFFF, r);
    check("bresp", sampler_pkg::RESP_SLVERR, r);
    axi_rd(sampler_pkg::DESC1_OFS, d);
    check("desc1", 0, d);
    for (int k = 0; k < 10; k++) run_req(cor[k][0], cor[k][1], cor[k][2], cor[k][3]);
    for (int n = 0; n < 8; n++) run_req(0, 32'h1C000000 | (n << 19), 0, 32'h8);
    for (int k = 0; k < 40; k++) begin
      lf = lfsr(lf);
      d1 = lf & 32'h003FFFFF;
      lf = lfsr(lf);
      d3 = lf & 32'h1FF80000;
      lf = lfsr(lf);
      lr = lf & 32'h03FF07FF;
      lf = lfsr(lf);
      c = lf & 32'h0001FFFF;
      if (c[4:2] > 3'h2) c[4:2] = 3'h1;
      if (c[7:5] > 3'h2) c[7:5] = 3'h1;
      if (c[0]) c[16] = 1'b0;
      run_req(d1, d3, lr, c);
    end
    stop_test();
  end
  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    stop_test();
  end
endmodule // test_texture_sampler_state_decode
`default_nettype wire
